/* hdl/gpio_port_pkg.sv */
// Constants and types for the eight-pin GPIO port
package gpio_port_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_DIR = 6'h00;
    localparam logic [5:0] IDX_DIR_SET = 6'h01;
    localparam logic [5:0] IDX_DIR_CLR = 6'h02;
    localparam logic [5:0] IDX_DIR_TGL = 6'h03;
    localparam logic [5:0] IDX_LVL = 6'h04;
    localparam logic [5:0] IDX_LVL_SET = 6'h05;
    localparam logic [5:0] IDX_LVL_CLR = 6'h06;
    localparam logic [5:0] IDX_LVL_TGL = 6'h07;
    localparam logic [5:0] IDX_SAMPLED = 6'h08;
    localparam logic [5:0] IDX_FLAGS = 6'h09;
    localparam logic [5:0] IDX_BANK = 6'h0a;
    localparam logic [5:0] IDX_PAD0 = 6'h10;
    localparam logic [5:0] IDX_PAD7 = 6'h17;

    // Field positions
    localparam int SLEW_BIT = 0;
    localparam int FLIP_BIT = 7;

    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SENSE_NONE = 3'h0,
        SENSE_BOTH = 3'h1,
        SENSE_RISE = 3'h2,
        SENSE_FALL = 3'h3,
        SENSE_OFF = 3'h4,
        SENSE_LOW = 3'h5
    } sense_type;

    typedef struct packed {
        logic polarity_flip;
        logic [2:0] sense_select;
    } pad_setup_type;

    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] data;
        logic strb;
    } wr_req_type;

endpackage

/* hdl/gpio_port_direction_output_input.sv */
// Eight-pin GPIO port with AXI4-Lite register access
`timescale 1ns/1ps
module gpio_port_direction_output_input (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic slew_limit,
    output logic irq
);

    ////////////////////////////////////////////////////////////////
    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx <= gpio_port_pkg::IDX_BANK) ||
            (idx >= gpio_port_pkg::IDX_PAD0 && idx <= gpio_port_pkg::IDX_PAD7);
    endfunction

    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    gpio_port_pkg::wr_req_type wr_reg, wr_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] dir_reg, dir_next;
    logic [7:0] lvl_reg, lvl_next;
    logic [7:0] sampled_reg, sampled_next;
    logic [7:0] flags_reg, flags_next;
    logic slew_reg, slew_next;
    gpio_port_pkg::pad_setup_type [7:0] setup_reg, setup_next;
    logic [7:0] sync1_reg, sync2_reg;
    logic [7:0] pad_out_reg, pad_out_next;
    logic [7:0] flip, buf_en, in_lvl, event_hit, clr_mask;
    logic do_wr, wr_ok;
    logic [7:0] wd;
    logic [5:0] ar_idx;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
    assign pad_oe = dir_reg;
    assign pad_out = pad_out_reg;
    assign slew_limit = slew_reg;
    assign irq = |flags_reg;

    // Both halves of a write may arrive in either order
    assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_ok = do_wr && wr_reg.strb && mapped(wr_reg.idx);
    assign wd = wr_reg.data;
    assign ar_idx = s_axi_araddr[7:2];

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        wr_next = wr_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && !aw_full_reg)
        begin
            aw_full_next = 1'b1;
            wr_next.idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && !w_full_reg)
        begin
            w_full_next = 1'b1;
            wr_next.data = s_axi_wdata[7:0];
            wr_next.strb = s_axi_wstrb[0];
        end
        if (do_wr)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = mapped(wr_reg.idx) ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            wr_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= gpio_port_pkg::RESP_OKAY;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            wr_reg <= wr_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = mapped(ar_idx) ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
            rdata_next = gpio_port_pkg::RESET_VALUE;
            case (ar_idx)
                gpio_port_pkg::IDX_DIR,
                gpio_port_pkg::IDX_DIR_SET,
                gpio_port_pkg::IDX_DIR_CLR,
                gpio_port_pkg::IDX_DIR_TGL: rdata_next = dir_reg;
                gpio_port_pkg::IDX_LVL,
                gpio_port_pkg::IDX_LVL_SET,
                gpio_port_pkg::IDX_LVL_CLR,
                gpio_port_pkg::IDX_LVL_TGL: rdata_next = lvl_reg;
                gpio_port_pkg::IDX_SAMPLED: rdata_next = sampled_reg;
                gpio_port_pkg::IDX_FLAGS: rdata_next = flags_reg;
                gpio_port_pkg::IDX_BANK: rdata_next = {7'h00, slew_reg};
                default:
                begin
                    if (ar_idx >= gpio_port_pkg::IDX_PAD0 && ar_idx <= gpio_port_pkg::IDX_PAD7)
                        rdata_next = {setup_reg[ar_idx[2:0]].polarity_flip, 4'h0,
                            setup_reg[ar_idx[2:0]].sense_select};
                end
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= gpio_port_pkg::RESP_OKAY;
            rdata_reg <= gpio_port_pkg::RESET_VALUE;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sense decode per pin; edges compare against the held sample
    genvar n;
    generate
        for (n = 0; n < 8; n++)
        begin : g_pin
            logic [2:0] sel;
            assign sel = setup_reg[n].sense_select;
            assign flip[n] = setup_reg[n].polarity_flip;
            assign buf_en[n] = (sel != gpio_port_pkg::SENSE_OFF);
            assign in_lvl[n] = sync2_reg[n] ^ flip[n];
            always_comb
            begin
                case (sel)
                    gpio_port_pkg::SENSE_BOTH: event_hit[n] = in_lvl[n] != sampled_reg[n];
                    gpio_port_pkg::SENSE_RISE: event_hit[n] = in_lvl[n] && !sampled_reg[n];
                    gpio_port_pkg::SENSE_FALL: event_hit[n] = !in_lvl[n] && sampled_reg[n];
                    gpio_port_pkg::SENSE_LOW: event_hit[n] = !in_lvl[n];
                    default: event_hit[n] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign clr_mask = (wr_ok && wr_reg.idx == gpio_port_pkg::IDX_FLAGS) ? wd : 8'h00;

    always_comb
    begin
        dir_next = dir_reg;
        lvl_next = lvl_reg;
        slew_next = slew_reg;
        setup_next = setup_reg;
        // A new event wins over a clear in the same cycle
        flags_next = (flags_reg & ~clr_mask) | event_hit;
        sampled_next = (in_lvl & buf_en) | (sampled_reg & ~buf_en);
        if (wr_ok)
        begin
            case (wr_reg.idx)
                gpio_port_pkg::IDX_DIR: dir_next = wd;
                gpio_port_pkg::IDX_DIR_SET: dir_next = dir_reg | wd;
                gpio_port_pkg::IDX_DIR_CLR: dir_next = dir_reg & ~wd;
                gpio_port_pkg::IDX_DIR_TGL: dir_next = dir_reg ^ wd;
                gpio_port_pkg::IDX_LVL: lvl_next = wd;
                gpio_port_pkg::IDX_LVL_SET: lvl_next = lvl_reg | wd;
                gpio_port_pkg::IDX_LVL_CLR: lvl_next = lvl_reg & ~wd;
                gpio_port_pkg::IDX_LVL_TGL,
                gpio_port_pkg::IDX_SAMPLED: lvl_next = lvl_reg ^ wd;
                gpio_port_pkg::IDX_BANK: slew_next = wd[gpio_port_pkg::SLEW_BIT];
                default:
                begin
                    if (wr_reg.idx >= gpio_port_pkg::IDX_PAD0)
                    begin
                        setup_next[wr_reg.idx[2:0]].polarity_flip = wd[gpio_port_pkg::FLIP_BIT];
                        setup_next[wr_reg.idx[2:0]].sense_select = wd[2:0];
                    end
                end
            endcase
        end
        // Level seen on the pad only matters while the driver is on
        pad_out_next = lvl_next;
        for (int i = 0; i < 8; i++)
            pad_out_next[i] = lvl_next[i] ^ setup_next[i].polarity_flip;
    end

    // Two stages absorb metastability; first stage feeds only the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= gpio_port_pkg::RESET_VALUE;
            sync2_reg <= gpio_port_pkg::RESET_VALUE;
            dir_reg <= gpio_port_pkg::RESET_VALUE;
            lvl_reg <= gpio_port_pkg::RESET_VALUE;
            sampled_reg <= gpio_port_pkg::RESET_VALUE;
            flags_reg <= gpio_port_pkg::RESET_VALUE;
            slew_reg <= 1'b0;
            setup_reg <= '0;
            pad_out_reg <= gpio_port_pkg::RESET_VALUE;
        end
        else
        begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
            dir_reg <= dir_next;
            lvl_reg <= lvl_next;
            sampled_reg <= sampled_next;
            flags_reg <= flags_next;
            slew_reg <= slew_next;
            setup_reg <= setup_next;
            pad_out_reg <= pad_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic wr_dir_set, wr_dir_clr, wr_dir_tgl, wr_lvl_tgl;
    assign wr_dir_set = wr_ok && wr_reg.idx == gpio_port_pkg::IDX_DIR_SET;
    assign wr_dir_clr = wr_ok && wr_reg.idx == gpio_port_pkg::IDX_DIR_CLR;
    assign wr_dir_tgl = wr_ok && wr_reg.idx == gpio_port_pkg::IDX_DIR_TGL;
    assign wr_lvl_tgl = wr_ok && (wr_reg.idx == gpio_port_pkg::IDX_LVL_TGL ||
        wr_reg.idx == gpio_port_pkg::IDX_SAMPLED);

    property p_dir_set;
        wr_dir_set |=> dir_reg == ($past(dir_reg) | $past(wd));
    endproperty
    a_dir_set: assert property (p_dir_set) else $error("dir set failed");

    property p_dir_clr;
        wr_dir_clr |=> dir_reg == ($past(dir_reg) & ~$past(wd));
    endproperty
    a_dir_clr: assert property (p_dir_clr) else $error("dir clear failed");

    property p_dir_tgl;
        wr_dir_tgl |=> pad_oe == ($past(dir_reg) ^ $past(wd));
    endproperty
    a_dir_tgl: assert property (p_dir_tgl) else $error("dir toggle failed");

    property p_dir_alias_rd;
        s_axi_arvalid && s_axi_arready && ar_idx == gpio_port_pkg::IDX_DIR_CLR
            |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(dir_reg);
    endproperty
    a_dir_alias_rd: assert property (p_dir_alias_rd) else $error("alias read wrong");

    property p_zero_write;
        (wr_dir_set || wr_dir_clr || wr_dir_tgl) && wd == 8'h00 |=> $stable(dir_reg);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed state");

    property p_lvl_tgl;
        wr_lvl_tgl |=> lvl_reg == ($past(lvl_reg) ^ $past(wd));
    endproperty
    a_lvl_tgl: assert property (p_lvl_tgl) else $error("level toggle failed");

    property p_hold;
        !buf_en[0] |=> $stable(sampled_reg[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("sample changed while off");

    property p_pad_to_sample;
        $rose(pad_in[0]) && flip[0] == 1'b0 && buf_en[0] ##1 buf_en[0] && $stable(flip[0]) [*2]
            |=> sampled_reg[0];
    endproperty
    a_pad_to_sample: assert property (p_pad_to_sample) else $error("pad not sampled");

    property p_low_level;
        setup_reg[0].sense_select == gpio_port_pkg::SENSE_LOW && !in_lvl[0] |=> flags_reg[0];
    endproperty
    a_low_level: assert property (p_low_level) else $error("low level flag missing");

    property p_flag_clr;
        clr_mask[1] && !event_hit[1] |=> !flags_reg[1];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_irq;
        event_hit != 8'h00 |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_drive;
        pad_out[2] == (lvl_reg[2] ^ flip[2]);
    endproperty
    a_drive: assert property (p_drive) else $error("pad level wrong");

    c_write: cover property (do_wr && wr_reg.idx == gpio_port_pkg::IDX_LVL_SET);
    c_edge: cover property (event_hit[0] && setup_reg[0].sense_select == gpio_port_pkg::SENSE_BOTH);
    c_set_clr: cover property (clr_mask[0] && event_hit[0]);
    c_read: cover property (s_axi_rvalid && s_axi_rready);

endmodule // gpio_port_direction_output_input

/* dv/gpio_pad_model.sv */
// Pad model: the port's own drivers and the outside world on one wire per pin
`timescale 1ns/1ps
module gpio_pad_model (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    // A driven pin shows the port's level, a released one the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // gpio_pad_model

/* dv/gpio_port_direction_output_input_test.sv */
// Self-checking testbench for the eight-pin GPIO port
`timescale 1ns/1ps
module gpio_port_direction_output_input_test;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, slew_limit, irq;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] pad_in, pad_out, pad_oe, ext_level;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    gpio_port_direction_output_input i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .slew_limit(slew_limit), .irq(irq));

    gpio_pad_model i_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Ready is sampled at the falling edge, so the rising edge that takes it needs no race
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = gpio_port_pkg::RESP_OKAY);
        logic a, w;
        logic [1:0] resp;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {24'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w))
        begin
            @(negedge aclk);
            a = a | awready;
            w = w | wready;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        a = 1'b0;
        while (!a)
        begin
            @(negedge aclk);
            a = bvalid;
            resp = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        @(posedge aclk);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er = gpio_port_pkg::RESP_OKAY);
        logic a;
        logic [31:0] d;
        logic [1:0] resp;
        a = 1'b0;
        araddr <= {24'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!a)
        begin
            @(negedge aclk);
            a = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        a = 1'b0;
        while (!a)
        begin
            @(negedge aclk);
            a = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
        @(posedge aclk);
        chk(d, {24'h0, e});
        chk({30'h0, resp}, {30'h0, er});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({8'h0, pad_oe, pad_out, 7'h0, irq}, 32'h0);
        rd(gpio_port_pkg::IDX_DIR, 8'h00);
        rd(gpio_port_pkg::IDX_LVL, 8'h00);
        rd(gpio_port_pkg::IDX_FLAGS, 8'h00);
        rd(gpio_port_pkg::IDX_BANK, 8'h00);
        rd(gpio_port_pkg::IDX_PAD7, 8'h00);
    endtask

    task automatic t_dir;
        wr(gpio_port_pkg::IDX_DIR_SET, 8'ha5);
        chk({24'h0, pad_oe}, 32'ha5);
        rd(gpio_port_pkg::IDX_DIR_SET, 8'ha5);
        wr(gpio_port_pkg::IDX_DIR_CLR, 8'h05);
        rd(gpio_port_pkg::IDX_DIR_CLR, 8'ha0);
        wr(gpio_port_pkg::IDX_DIR_TGL, 8'h0f);
        rd(gpio_port_pkg::IDX_DIR_TGL, 8'haf);
        wr(gpio_port_pkg::IDX_DIR_SET, 8'h00);
        wr(gpio_port_pkg::IDX_DIR_TGL, 8'h00);
        rd(gpio_port_pkg::IDX_DIR, 8'haf);
        chk({24'h0, pad_oe}, 32'haf);
        wr(gpio_port_pkg::IDX_DIR, 8'h00);
    endtask

    task automatic t_lvl;
        wr(gpio_port_pkg::IDX_LVL_SET, 8'h3c);
        rd(gpio_port_pkg::IDX_LVL_SET, 8'h3c);
        chk({24'h0, pad_out}, 32'h3c);
        wr(gpio_port_pkg::IDX_LVL_CLR, 8'h0c);
        rd(gpio_port_pkg::IDX_LVL_CLR, 8'h30);
        wr(gpio_port_pkg::IDX_LVL_TGL, 8'h11);
        rd(gpio_port_pkg::IDX_LVL_TGL, 8'h21);
        wr(gpio_port_pkg::IDX_SAMPLED, 8'h01);
        wr(gpio_port_pkg::IDX_LVL_CLR, 8'h00);
        rd(gpio_port_pkg::IDX_LVL, 8'h20);
        // Only the two enabled pins (0 and 5) reach the wire, pin 0 driving low; the others read the outside low
        wr(gpio_port_pkg::IDX_DIR, 8'h21);
        repeat (4) @(posedge aclk);
        rd(gpio_port_pkg::IDX_SAMPLED, 8'h20);
        wr(gpio_port_pkg::IDX_DIR, 8'h00);
        wr(gpio_port_pkg::IDX_LVL, 8'h00);
    endtask

    task automatic t_in;
        ext_level <= 8'hc3;
        repeat (4) @(posedge aclk);
        rd(gpio_port_pkg::IDX_SAMPLED, 8'hc3);
        wr(6'h11, {5'h0, gpio_port_pkg::SENSE_OFF});
        ext_level <= 8'h00;
        repeat (4) @(posedge aclk);
        rd(gpio_port_pkg::IDX_SAMPLED, 8'h02);
        wr(6'h11, 8'h00);
        repeat (4) @(posedge aclk);
        wr(gpio_port_pkg::IDX_FLAGS, 8'hff);
    endtask

    // Rising, falling and staying low, for every sense code on pin 0
    task automatic t_evt;
        logic [7:0] rise_t, fall_t, stay_t;
        rise_t = 8'b00100110;
        fall_t = 8'b00101010;
        stay_t = 8'b00100000;
        for (int i = 0; i < 8; i++)
        begin
            wr(gpio_port_pkg::IDX_PAD0, 8'(i));
            repeat (4) @(posedge aclk);
            wr(gpio_port_pkg::IDX_FLAGS, 8'hff);
            ext_level <= 8'h01;
            repeat (4) @(posedge aclk);
            chk({31'h0, irq}, {31'h0, rise_t[i]});
            rd(gpio_port_pkg::IDX_FLAGS, {7'h0, rise_t[i]});
            wr(gpio_port_pkg::IDX_FLAGS, 8'h00);
            wr(gpio_port_pkg::IDX_FLAGS, 8'hff);
            ext_level <= 8'h00;
            repeat (4) @(posedge aclk);
            rd(gpio_port_pkg::IDX_FLAGS, {7'h0, fall_t[i]});
            wr(gpio_port_pkg::IDX_FLAGS, 8'hff);
            rd(gpio_port_pkg::IDX_FLAGS, {7'h0, stay_t[i]});
            chk({31'h0, irq}, {31'h0, stay_t[i]});
        end
        wr(gpio_port_pkg::IDX_PAD0, 8'h00);
        wr(gpio_port_pkg::IDX_FLAGS, 8'hff);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_misc;
        wr(6'h11, 8'h80);
        repeat (4) @(posedge aclk);
        rd(gpio_port_pkg::IDX_SAMPLED, 8'h02);
        chk({24'h0, pad_out}, 32'h02);
        wr(gpio_port_pkg::IDX_BANK, 8'h01);
        chk({31'h0, slew_limit}, 32'h1);
        rd(gpio_port_pkg::IDX_BANK, 8'h01);
        // A write with its byte lane off is answered but changes nothing
        wstrb <= 4'h0;
        wr(gpio_port_pkg::IDX_BANK, 8'h00);
        wstrb <= 4'h1;
        rd(gpio_port_pkg::IDX_BANK, 8'h01);
        // An unmapped word is refused and must not disturb the port
        wr(6'h0f, 8'hff, gpio_port_pkg::RESP_SLVERR);
        rd(6'h3f, 8'h00, gpio_port_pkg::RESP_SLVERR);
        rd(gpio_port_pkg::IDX_DIR, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("ERROR %0t: run did not complete", $time);
            finish_test;
        end
    end

    initial
    begin
        aresetn <= 1'b0;
        {awaddr, wdata, araddr} <= 96'h0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
        wstrb <= 4'h1;
        ext_level <= 8'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_dir;
        t_lvl;
        t_in;
        t_evt;
        t_misc;
        // A second reset in mid-run must clear state that is far from zero
        wr(gpio_port_pkg::IDX_DIR, 8'hff);
        wr(gpio_port_pkg::IDX_PAD7, 8'h85);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        finish_test;
    end
endmodule // gpio_port_direction_output_input_test
